// File: bench/src_readout_regs_chk.sv
`timescale 1ns/1ps
module src_readout_regs_chk #(
  parameter int HADDR_W = 32
) (
  input wire logic               sys_clk,
  input wire logic               rst_n,
  input wire logic               hsel,
  input wire logic [HADDR_W-1:0] haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic               frame_req,
  input wire logic               ext_int1,
  input wire src_pkg::src_cfg_t  cfg,
  input wire logic               slot_valid_strobe,
  input wire logic               knee1_pulse,
  input wire logic               seq_busy
);
  import src_pkg::*;
  logic       wp;
  logic [6:0] wi;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr(logic [6:0] i);
    wp && wi == i;
  endsequence
  // Marks the data phase of a taken write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= 1'b0;
      wi <= 7'h00;
    end else begin
      wp <= hsel & htrans[1] & hready & hwrite & (haddr[HADDR_W-1:9] == '0);
      wi <= haddr[8:2];
    end
  end
  a_flip_bits: assert property (s_wr(IDX_FLIP) |=> cfg.mirror_x == $past(hwdata[0]))
    else $error("mirror bit not written");
  a_integ_bits: assert property (s_wr(IDX_INTEG) |=>
    {cfg.integ_sync, cfg.integ_dual, cfg.integ_ext} == $past(hwdata[2:0]))
    else $error("integration bits not written");
  a_exp_low: assert property (s_wr(IDX_EXP1) |=> cfg.group1_exposure_len[7:0] == $past(hwdata[7:0]))
    else $error("exposure low byte not written");
  a_knee2_top: assert property (s_wr(IDX_KNEE2 + 7'h02) |=>
    cfg.knee2_exposure[23:16] == $past(hwdata[7:0]))
    else $error("knee two top byte not written");
  a_slot_period: assert property (slot_valid_strobe && cfg.cycles_per_slot == 8'h04 |=>
    !slot_valid_strobe [*3] ##1 slot_valid_strobe)
    else $error("slot length wrong");
  a_req_starts: assert property (frame_req && !seq_busy && !cfg.integ_ext &&
    cfg.frames_per_request != 16'h0000 |=> seq_busy)
    else $error("frame request not taken");
  a_ext_refuses: assert property (frame_req && !seq_busy && cfg.integ_ext && !ext_int1 &&
    !$past(ext_int1) |=> !seq_busy)
    else $error("frame request taken in external mode");
  a_knee_gated: assert property (knee1_pulse |-> $past(seq_busy) &&
    !$past(cfg.integ_ext) && $past(cfg.hdr_slopes) >= 2'h2)
    else $error("knee pulse out of mode");
endmodule
bind src_readout_regs src_readout_regs_chk #(.HADDR_W(HADDR_W)) chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .frame_req(frame_req),
  .ext_int1(ext_int1), .cfg(cfg), .slot_valid_strobe(slot_valid_strobe),
  .knee1_pulse(knee1_pulse), .seq_busy(seq_busy)
);

// File: bench/src_readout_regs_tb.sv
`timescale 1ns/1ps
module src_readout_regs_tb;
  import src_pkg::*;
  logic             sys_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             hsel = 1'b0;
  logic [31:0]      haddr = 32'h0;
  logic [1:0]       htrans = 2'h0;
  logic             hwrite = 1'b0;
  logic [31:0]      hwdata = 32'h0;
  logic             frame_req = 1'b0;
  logic             ext_int1 = 1'b0;
  logic [4:0][15:0] low_rows = '0;
  logic             hreadyout, rv, g1, g2, k2, hresp_o, busy;
  logic [2:0]       rwin;
  logic [31:0]      hrdata, rd;
  logic [15:0]      rrow;
  logic [15:0]      rows[$];
  logic [6:0]       i;
  logic [7:0]       v;
  logic [7:0]       b[3];
  src_cfg_t         cfg;
  int               error_cnt = 0, checks = 0, seed = 32'hd9c3, exp_n = 0, exp2_n = 0, k2_n = 0;
  logic [6:0] ri[19] = '{IDX_WIN5_FIRST, IDX_WIN7_COUNT, IDX_FLIP, IDX_INTEG, IDX_EXP1,
    IDX_EXP1 + 7'h01, IDX_SLOPES, IDX_FRAMES, IDX_TRAIN, IDX_FILLER, IDX_MUX, IDX_SHUT,
    IDX_SLOT, IDX_ROWLEN, IDX_SMP_LEN, IDX_SMP_OPT, IDX_RRAMP, IDX_GAP, IDX_SRAMP};
  logic [7:0] rv0[19] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'hC0, 8'h13, 8'h01, 8'h01, 8'h55,
    8'h01, 8'h01, 8'h07, 8'h70, 8'h02, 8'h60, 8'h10, 8'h29, 8'h01, 8'h90};
  logic [6:0] si[10] = '{IDX_SLOT, IDX_EXP1, IDX_EXP1 + 7'h01, IDX_SLOPES, IDX_KNEE1,
    IDX_WIN0_COUNT, IDX_G1_SKIP, IDX_G2_SKIP, IDX_WIN5_FIRST, IDX_WIN5_COUNT};
  logic [7:0] sv[10] = '{8'h04, 8'h14, 8'h00, 8'h02, 8'h05, 8'h03, 8'h01, 8'h02, 8'h30, 8'h01};
  logic [15:0] er[4] = '{16'h000B, 16'h000E, 16'h0010, 16'h0030};
  logic [6:0] di[5] = '{IDX_INTEG, IDX_EXP2, IDX_SLOPES, IDX_KNEE2, IDX_FRAMES};
  logic [7:0] dv[5] = '{8'h02, 8'h1A, 8'h03, 8'h07, 8'h02};
  always #2.5 sys_clk = ~sys_clk;
  src_readout_regs dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp_o), .hrdata(hrdata), .frame_req(frame_req),
    .ext_int1(ext_int1), .ext_int2(1'b0), .low_win_first_row(low_rows), .cfg(cfg),
    .slot_valid_strobe(), .row_read_valid(rv), .read_row(rrow), .read_window(rwin),
    .expose_group1(g1), .expose_group2(g2), .knee1_pulse(), .knee2_pulse(k2), .seq_busy(busy)
  );
  // Rows read and exposure cycles
  always @(posedge sys_clk) begin
    if (rv === 1'b1) rows.push_back(rrow);
    if (g1 === 1'b1) exp_n++;
    if (g2 === 1'b1) exp2_n++;
    if (k2 === 1'b1) k2_n++;
  end
  function automatic logic [7:0] wmask(logic [6:0] x);
    case (x)
      IDX_FLIP, IDX_SLOPES, IDX_SRAMP + 7'h01: return 8'h03;
      IDX_INTEG: return 8'h07;
      IDX_TRAIN + 7'h01, IDX_SHUT: return 8'h0F;
      IDX_MUX: return 8'h1F;
      IDX_ROWLEN: return 8'h7F;
      IDX_SMP_OPT: return 8'h14;
      IDX_RRAMP + 7'h01: return 8'h01;
      IDX_CONV_TEST: return 8'h08;
      IDX_RSVD_A, IDX_RSVD_B, IDX_RSVD_C, IDX_RSVD_D, IDX_RSVD_E, IDX_RSVD_F: return 8'h00;
      default: return 8'hFF;
    endcase
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] want);
    checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, want, seen);
    end
  endtask
  // One single transfer, address phase then data phase
  task automatic bus(logic [6:0] x, logic wr, logic [7:0] wd, output logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {23'h0, x, 2'h0};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    d = hrdata;
  endtask
  // Starts a frame by request or external level, then waits for idle
  task automatic run(logic ext);
    frame_req <= !ext;
    ext_int1 <= ext;
    repeat (6) @(posedge sys_clk);
    frame_req <= 1'b0;
    ext_int1 <= 1'b0;
    for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge sys_clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (ri[k]) begin
      bus(ri[k], 1'b0, 8'h00, rd);
      chk($sformatf("reset of %h", ri[k]), rd, {24'h0, rv0[k]});
    end
    $display("reset test done");
    low_rows[0] <= 16'h000B;
    foreach (si[k]) bus(si[k], 1'b1, sv[k], rd);
    run(1'b0);
    foreach (er[k]) chk("row", {16'h0, rows[k]}, {16'h0, er[k]});
    chk("row count", 32'(rows.size()), 32'h4);
    chk("exposure", 32'(exp_n), 32'h14);
    chk("window", {29'h0, rwin}, 32'h5);
    foreach (di[k]) bus(di[k], 1'b1, dv[k], rd);
    run(1'b0);
    chk("rows of two frames", 32'(rows.size()), 32'hC);
    chk("group one cycles", 32'(exp_n), 32'h3C);
    chk("group two cycles", 32'(exp2_n), 32'h48);
    chk("knee two pulses", 32'(k2_n), 32'h2);
    $display("frame test done");
    bus(IDX_INTEG, 1'b1, 8'h05, rd);
    frame_req <= 1'b1;
    repeat (2) @(posedge sys_clk);
    frame_req <= 1'b0;
    chk("busy in external mode", {31'h0, busy}, 32'h0);
    @(posedge sys_clk);
    run(1'b1);
    chk("rows of external frame", 32'(rows.size()), 32'h10);
    chk("external group one", 32'(exp_n), 32'h41);
    chk("external group two", 32'(exp2_n), 32'h4D);
    for (int k = 0; k < 40; k++) begin
      i = 7'h0D + 7'($random(seed) & 63);
      if (i == IDX_SLOT) i = IDX_FILLER;
      v = 8'($random(seed));
      bus(i, 1'b1, v, rd);
      bus(i, 1'b0, 8'h00, rd);
      chk($sformatf("readback of %h", i), rd, {24'h0, v & wmask(i)});
    end
    for (int k = 0; k < 3; k++) begin
      b[k] = 8'($random(seed));
      bus(IDX_KNEE2 + 7'(k), 1'b1, b[k], rd);
    end
    @(posedge sys_clk);
    chk("knee two", {8'h0, cfg.knee2_exposure}, {8'h0, b[2], b[1], b[0]});
    bus(7'h7F, 1'b1, 8'hFF, rd);
    bus(7'h7F, 1'b0, 8'h00, rd);
    chk("unmapped", rd, 32'h0);
    chk("response", {31'h0, hresp_o}, 32'h0);
    $display("register test done");
    complete_run();
  end
endmodule

// File: common/src_pkg.sv
package src_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [6:0] IDX_WIN5_FIRST  = 7'h0D;
  localparam logic [6:0] IDX_WIN6_FIRST  = 7'h0F;
  localparam logic [6:0] IDX_WIN7_FIRST  = 7'h11;
  localparam logic [6:0] IDX_WIN0_COUNT  = 7'h13;
  localparam logic [6:0] IDX_WIN1_COUNT  = 7'h15;
  localparam logic [6:0] IDX_WIN2_COUNT  = 7'h17;
  localparam logic [6:0] IDX_WIN3_COUNT  = 7'h19;
  localparam logic [6:0] IDX_WIN4_COUNT  = 7'h1B;
  localparam logic [6:0] IDX_WIN5_COUNT  = 7'h1D;
  localparam logic [6:0] IDX_WIN6_COUNT  = 7'h1F;
  localparam logic [6:0] IDX_WIN7_COUNT  = 7'h21;
  localparam logic [6:0] IDX_G1_SKIP     = 7'h23;
  localparam logic [6:0] IDX_G2_SKIP     = 7'h25;
  localparam logic [6:0] IDX_FLIP        = 7'h27;
  localparam logic [6:0] IDX_INTEG       = 7'h28;
  localparam logic [6:0] IDX_EXP1        = 7'h29;
  localparam logic [6:0] IDX_EXP2        = 7'h2C;
  localparam logic [6:0] IDX_SLOPES      = 7'h2F;
  localparam logic [6:0] IDX_KNEE1       = 7'h30;
  localparam logic [6:0] IDX_KNEE2       = 7'h33;
  localparam logic [6:0] IDX_FRAMES      = 7'h36;
  localparam logic [6:0] IDX_TRAIN       = 7'h38;
  localparam logic [6:0] IDX_FILLER      = 7'h3A;
  localparam logic [6:0] IDX_MUX         = 7'h3B;
  localparam logic [6:0] IDX_SHUT        = 7'h3C;
  localparam logic [6:0] IDX_SLOT        = 7'h3D;
  localparam logic [6:0] IDX_ROWLEN      = 7'h3E;
  localparam logic [6:0] IDX_RSVD_A      = 7'h3F;
  localparam logic [6:0] IDX_RSVD_B      = 7'h40;
  localparam logic [6:0] IDX_SMP_LEN     = 7'h41;
  localparam logic [6:0] IDX_RSVD_C      = 7'h42;
  localparam logic [6:0] IDX_RSVD_D      = 7'h43;
  localparam logic [6:0] IDX_SMP_OPT     = 7'h44;
  localparam logic [6:0] IDX_RSVD_E      = 7'h45;
  localparam logic [6:0] IDX_RSVD_F      = 7'h46;
  localparam logic [6:0] IDX_RRAMP       = 7'h47;
  localparam logic [6:0] IDX_GAP         = 7'h49;
  localparam logic [6:0] IDX_SRAMP       = 7'h4A;
  localparam logic [6:0] IDX_CONV_TEST   = 7'h4C;
  localparam logic [6:0] IDX_SEQ_STATUS  = 7'h4D;

  // Byte-address slicing of haddr
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 8;

  // Writable bits per byte
  localparam logic [7:0] MASK_NONE      = 8'h00;
  localparam logic [7:0] MASK_FULL      = 8'hFF;
  localparam logic [7:0] MASK_FLIP      = 8'h03;
  localparam logic [7:0] MASK_INTEG     = 8'h07;
  localparam logic [7:0] MASK_SLOPES    = 8'h03;
  localparam logic [7:0] MASK_TRAIN_HI  = 8'h0F;
  localparam logic [7:0] MASK_MUX       = 8'h1F;
  localparam logic [7:0] MASK_SHUT      = 8'h0F;
  localparam logic [7:0] MASK_ROWLEN    = 8'h7F;
  localparam logic [7:0] MASK_SMP_OPT   = 8'h14;
  localparam logic [7:0] MASK_RRAMP_HI  = 8'h01;
  localparam logic [7:0] MASK_SRAMP_HI  = 8'h03;
  localparam logic [7:0] MASK_CONV_TEST = 8'h08;

  // Reset values
  localparam logic [23:0] RST_EXP1    = 24'h0013C0;
  localparam logic [7:0]  RST_INTEG   = 8'h04;
  localparam logic [7:0]  RST_SLOPES  = 8'h01;
  localparam logic [15:0] RST_FRAMES  = 16'h0001;
  localparam logic [15:0] RST_TRAIN   = 16'h0055;
  localparam logic [7:0]  RST_FILLER  = 8'h01;
  localparam logic [7:0]  RST_MUX     = 8'h01;
  localparam logic [7:0]  RST_SHUT    = 8'h07;
  localparam logic [7:0]  RST_SLOT    = 8'h70;
  localparam logic [7:0]  RST_ROWLEN  = 8'h02;
  localparam logic [7:0]  RST_SMP_LEN = 8'h60;
  localparam logic [7:0]  RST_SMP_OPT = 8'h10;
  localparam logic [15:0] RST_RRAMP   = 16'h0029;
  localparam logic [7:0]  RST_GAP     = 8'h01;
  localparam logic [15:0] RST_SRAMP   = 16'h0090;

  // Field bit positions
  localparam int FLIP_X_BIT       = 0;
  localparam int FLIP_Y_BIT       = 1;
  localparam int INTEG_EXT_BIT    = 0;
  localparam int INTEG_DUAL_BIT   = 1;
  localparam int INTEG_SYNC_BIT   = 2;
  localparam int SMP_PC_OFF_BIT   = 2;
  localparam int SMP_CLAMP_BIT    = 4;
  localparam int CONV_NO_RAMP_BIT = 3;

  // Sequencer constants
  localparam int         NUM_WIN      = 8;
  localparam int         NUM_LOW_WIN  = 5;
  localparam logic [2:0] LAST_WIN     = 3'h7;
  localparam logic [1:0] SLOPES_KNEE1 = 2'h2;
  localparam logic [1:0] SLOPES_KNEE2 = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SYNC   = 3'b001,
    ST_EXPOSE = 3'b010,
    ST_FILL   = 3'b011,
    ST_READ   = 3'b100
  } src_state_t;

  typedef struct packed {
    logic        mirror_x;
    logic        mirror_y;
    logic        integ_ext;
    logic        integ_dual;
    logic        integ_sync;
    logic [23:0] group1_exposure_len;
    logic [23:0] group2_exposure_len;
    logic [1:0]  hdr_slopes;
    logic [23:0] knee1_exposure;
    logic [23:0] knee2_exposure;
    logic [15:0] frames_per_request;
    logic [11:0] link_training_word;
    logic [7:0]  filler_row_count;
    logic [4:0]  output_lane_multiplex;
    logic [3:0]  output_lane_shutdown;
    logic [7:0]  cycles_per_slot;
    logic [6:0]  slots_per_row;
    logic [7:0]  sample_pulse_len;
    logic        column_precharge_off;
    logic        clamp_sig_level;
    logic [8:0]  reset_ramp_len;
    logic [7:0]  ramp_gap;
    logic [9:0]  signal_ramp_len;
    logic        no_ramp_ctrl;
  } src_cfg_t;

endpackage

// File: verilog/src_readout_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Windows five to seven hold start rows
// - Each window reads its programmed row count
// - Two group row-skip counts, default zero
// - Bit0 mirrors horizontally, bit1 vertically
// - Bit0 takes exposure from external inputs
// - Dual bit: odd/even rows use group lengths
// - Sync bit aligns internal integration to slot strobe
// - Group one exposure length, reset 5056
// - Group two exposure length, reset zero
// - Two-bit slope count, reset one
// - Two kneepoint exposure times, reset zero
// - Frame request yields programmed frames, internal only
// - Twelve-bit training word, reset 85
// - Filler rows inserted per frame, reset one
// - Five-bit lane multiplex select, reset one
// - Four-bit lane shutdown select, reset seven
// - Slot length in clock cycles, reset 112
// - Slots per row, reset two
// - Sampling pulse length, reset 96
// - Precharge suppress bit2, clamp level bit4
// - Reset ramp 9 bits 41, signal 10 bits 144
// - Ramp gap eight bits, reset one
module src_readout_regs #(
  parameter int HADDR_W = 32
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  hsel,
  input  wire logic [HADDR_W-1:0]    haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic                  frame_req,
  input  wire logic                  ext_int1,
  input  wire logic                  ext_int2,
  input  wire logic [4:0][15:0]      low_win_first_row,
  output src_pkg::src_cfg_t          cfg,
  output logic                       slot_valid_strobe,
  output logic                       row_read_valid,
  output logic [15:0]                read_row,
  output logic [2:0]                 read_window,
  output logic                       expose_group1,
  output logic                       expose_group2,
  output logic                       knee1_pulse,
  output logic                       knee2_pulse,
  output logic                       seq_busy
);
  import src_pkg::*;

  // Writable bits of each byte index
  function automatic logic [7:0] wr_mask(input logic [6:0] i);
    case (i)
      IDX_FLIP:        wr_mask = MASK_FLIP;
      IDX_INTEG:       wr_mask = MASK_INTEG;
      IDX_SLOPES:      wr_mask = MASK_SLOPES;
      IDX_TRAIN + 7'h01: wr_mask = MASK_TRAIN_HI;
      IDX_MUX:         wr_mask = MASK_MUX;
      IDX_SHUT:        wr_mask = MASK_SHUT;
      IDX_ROWLEN:      wr_mask = MASK_ROWLEN;
      IDX_RSVD_A, IDX_RSVD_B, IDX_RSVD_C, IDX_RSVD_D, IDX_RSVD_E, IDX_RSVD_F: begin
        wr_mask = MASK_NONE;
      end
      IDX_SMP_OPT:     wr_mask = MASK_SMP_OPT;
      IDX_RRAMP + 7'h01: wr_mask = MASK_RRAMP_HI;
      IDX_SRAMP + 7'h01: wr_mask = MASK_SRAMP_HI;
      IDX_CONV_TEST:   wr_mask = MASK_CONV_TEST;
      default: begin
        wr_mask = (i >= IDX_WIN5_FIRST && i < IDX_CONV_TEST) ? MASK_FULL : MASK_NONE;
      end
    endcase
  endfunction

  // Reset value of each byte index, low byte at the lower index
  function automatic logic [7:0] rst_byte(input logic [6:0] i);
    case (i)
      IDX_INTEG:         rst_byte = RST_INTEG;
      IDX_EXP1:          rst_byte = RST_EXP1[7:0];
      IDX_EXP1 + 7'h01:  rst_byte = RST_EXP1[15:8];
      IDX_EXP1 + 7'h02:  rst_byte = RST_EXP1[23:16];
      IDX_SLOPES:        rst_byte = RST_SLOPES;
      IDX_FRAMES:        rst_byte = RST_FRAMES[7:0];
      IDX_FRAMES + 7'h01: rst_byte = RST_FRAMES[15:8];
      IDX_TRAIN:         rst_byte = RST_TRAIN[7:0];
      IDX_TRAIN + 7'h01: rst_byte = RST_TRAIN[15:8];
      IDX_FILLER:        rst_byte = RST_FILLER;
      IDX_MUX:           rst_byte = RST_MUX;
      IDX_SHUT:          rst_byte = RST_SHUT;
      IDX_SLOT:          rst_byte = RST_SLOT;
      IDX_ROWLEN:        rst_byte = RST_ROWLEN;
      IDX_SMP_LEN:       rst_byte = RST_SMP_LEN;
      IDX_SMP_OPT:       rst_byte = RST_SMP_OPT;
      IDX_RRAMP:         rst_byte = RST_RRAMP[7:0];
      IDX_RRAMP + 7'h01: rst_byte = RST_RRAMP[15:8];
      IDX_GAP:           rst_byte = RST_GAP;
      IDX_SRAMP:         rst_byte = RST_SRAMP[7:0];
      IDX_SRAMP + 7'h01: rst_byte = RST_SRAMP[15:8];
      default:           rst_byte = MASK_NONE;
    endcase
  endfunction

  logic [7:0]  regs [0:IDX_CONV_TEST];
  logic        dp_write;
  logic [6:0]  dp_idx;
  logic [6:0]  ap_idx;
  logic        ap_hit;
  logic        ap_valid;
  logic [7:0]  ap_byte;
  logic [7:0]  status_byte;
  src_state_t  state;
  logic [15:0] win_first [0:NUM_WIN-1];
  logic [15:0] win_count [0:NUM_WIN-1];
  logic [7:0]  slot_cnt;
  logic [6:0]  slot_in_row;
  logic        slot_last;
  logic        row_tick;
  logic [23:0] exp_cnt;
  logic        exp1_done;
  logic        exp2_done;
  logic        ext_int1_d;
  logic [15:0] frames_left;
  logic [7:0]  fill_left;
  logic [15:0] rows_left;
  logic [15:0] row_addr;
  logic [2:0]  win;

  // Zero-wait slave with OKAY only
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase decode
  assign ap_idx   = haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
  assign ap_hit   = (haddr[HADDR_W-1:ADDR_IDX_MSB+1] == '0);
  assign ap_valid = hsel && htrans[1] && hready;

  // Read byte, forwarding a write still in its data phase
  always_comb begin
    if (dp_write && dp_idx == ap_idx) begin
      ap_byte = hwdata[7:0] & wr_mask(ap_idx);
    end else if (ap_idx == IDX_SEQ_STATUS) begin
      ap_byte = status_byte;
    end else if (ap_idx <= IDX_CONV_TEST) begin
      ap_byte = regs[ap_idx];
    end else begin
      ap_byte = MASK_NONE;
    end
    if (!ap_hit) begin
      ap_byte = MASK_NONE;
    end
  end

  assign status_byte = {2'b00, win, state};

  // Capture write address phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_write <= 1'b0;
      dp_idx   <= '0;
    end else if (hready) begin
      dp_write <= ap_valid && hwrite && ap_hit;
      dp_idx   <= ap_idx;
    end
  end

  // Read data register, loaded in the address phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= '0;
    end else if (ap_valid && !hwrite) begin
      hrdata <= {24'h000000, ap_byte};
    end
  end

  // Byte-wide register storage, reserved bits forced to zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i <= IDX_CONV_TEST; i++) begin
        regs[i] <= rst_byte(7'(i));
      end
    end else if (dp_write && dp_idx <= IDX_CONV_TEST) begin
      regs[dp_idx] <= hwdata[7:0] & wr_mask(dp_idx);
    end
  end

  // Window start rows and row counts, low byte first
  always_comb begin
    for (int w = 0; w < NUM_WIN; w++) begin
      win_count[w] = {regs[IDX_WIN0_COUNT + 7'(2*w) + 7'h01],
                      regs[IDX_WIN0_COUNT + 7'(2*w)]};
      if (w < NUM_LOW_WIN) begin
        win_first[w] = low_win_first_row[w];
      end else begin
        win_first[w] = {regs[IDX_WIN5_FIRST + 7'(2*(w-NUM_LOW_WIN)) + 7'h01],
                        regs[IDX_WIN5_FIRST + 7'(2*(w-NUM_LOW_WIN))]};
      end
    end
  end

  // Configuration fields presented to the sequencer and analog side
  always_comb begin
    cfg.mirror_x              = regs[IDX_FLIP][FLIP_X_BIT];
    cfg.mirror_y              = regs[IDX_FLIP][FLIP_Y_BIT];
    cfg.integ_ext             = regs[IDX_INTEG][INTEG_EXT_BIT];
    cfg.integ_dual            = regs[IDX_INTEG][INTEG_DUAL_BIT];
    cfg.integ_sync            = regs[IDX_INTEG][INTEG_SYNC_BIT];
    cfg.group1_exposure_len   = {regs[IDX_EXP1 + 7'h02], regs[IDX_EXP1 + 7'h01],
                                 regs[IDX_EXP1]};
    cfg.group2_exposure_len   = {regs[IDX_EXP2 + 7'h02], regs[IDX_EXP2 + 7'h01],
                                 regs[IDX_EXP2]};
    cfg.hdr_slopes            = regs[IDX_SLOPES][1:0];
    cfg.knee1_exposure        = {regs[IDX_KNEE1 + 7'h02], regs[IDX_KNEE1 + 7'h01],
                                 regs[IDX_KNEE1]};
    cfg.knee2_exposure        = {regs[IDX_KNEE2 + 7'h02], regs[IDX_KNEE2 + 7'h01],
                                 regs[IDX_KNEE2]};
    cfg.frames_per_request    = {regs[IDX_FRAMES + 7'h01], regs[IDX_FRAMES]};
    cfg.link_training_word    = {regs[IDX_TRAIN + 7'h01][3:0], regs[IDX_TRAIN]};
    cfg.filler_row_count      = regs[IDX_FILLER];
    cfg.output_lane_multiplex = regs[IDX_MUX][4:0];
    cfg.output_lane_shutdown  = regs[IDX_SHUT][3:0];
    cfg.cycles_per_slot       = regs[IDX_SLOT];
    cfg.slots_per_row         = regs[IDX_ROWLEN][6:0];
    cfg.sample_pulse_len      = regs[IDX_SMP_LEN];
    cfg.column_precharge_off  = regs[IDX_SMP_OPT][SMP_PC_OFF_BIT];
    cfg.clamp_sig_level       = regs[IDX_SMP_OPT][SMP_CLAMP_BIT];
    cfg.reset_ramp_len        = {regs[IDX_RRAMP + 7'h01][0], regs[IDX_RRAMP]};
    cfg.ramp_gap              = regs[IDX_GAP];
    cfg.signal_ramp_len       = {regs[IDX_SRAMP + 7'h01][1:0], regs[IDX_SRAMP]};
    cfg.no_ramp_ctrl          = regs[IDX_CONV_TEST][CONV_NO_RAMP_BIT];
  end

  // Slot and row timing; zero settings behave as one
  assign slot_last = (slot_cnt + 8'h01 >= cfg.cycles_per_slot);
  assign row_tick  = slot_last && (slot_in_row + 7'h01 >= cfg.slots_per_row);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_cnt          <= '0;
      slot_in_row       <= '0;
      slot_valid_strobe <= 1'b0;
    end else begin
      slot_valid_strobe <= slot_last;
      if (slot_last) begin
        slot_cnt    <= '0;
        slot_in_row <= row_tick ? 7'h00 : slot_in_row + 7'h01;
      end else begin
        slot_cnt <= slot_cnt + 8'h01;
      end
    end
  end

  // Internal exposure progress per group
  assign exp1_done = (exp_cnt >= cfg.group1_exposure_len);
  assign exp2_done = !cfg.integ_dual || (exp_cnt >= cfg.group2_exposure_len);

  // Frame sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state          <= ST_IDLE;
      ext_int1_d     <= 1'b0;
      exp_cnt        <= '0;
      frames_left    <= '0;
      fill_left      <= '0;
      rows_left      <= '0;
      row_addr       <= '0;
      win            <= '0;
      row_read_valid <= 1'b0;
      read_row       <= '0;
      read_window    <= '0;
    end else begin
      ext_int1_d     <= ext_int1;
      row_read_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cfg.integ_ext) begin
            if (ext_int1 && !ext_int1_d) begin
              state <= ST_EXPOSE;
            end
          end else if (frame_req && cfg.frames_per_request != '0) begin
            frames_left <= cfg.frames_per_request;
            state       <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          exp_cnt <= '0;
          if (!cfg.integ_sync || slot_last) begin
            state <= ST_EXPOSE;
          end
        end
        ST_EXPOSE: begin
          exp_cnt <= exp_cnt + 24'h000001;
          if (cfg.integ_ext ? !ext_int1 : (exp1_done && exp2_done)) begin
            fill_left <= cfg.filler_row_count;
            state     <= ST_FILL;
          end
        end
        ST_FILL: begin
          if (fill_left == '0) begin
            win       <= '0;
            row_addr  <= win_first[0];
            rows_left <= win_count[0];
            state     <= ST_READ;
          end else if (row_tick) begin
            fill_left <= fill_left - 8'h01;
          end
        end
        ST_READ: begin
          if (rows_left == '0) begin
            if (win == LAST_WIN) begin
              frames_left <= frames_left - 16'h0001;
              state <= (!cfg.integ_ext && frames_left > 16'h0001) ? ST_SYNC : ST_IDLE;
            end else begin
              win       <= win + 3'h1;
              row_addr  <= win_first[win + 3'h1];
              rows_left <= win_count[win + 3'h1];
            end
          end else if (row_tick) begin
            row_read_valid <= 1'b1;
            read_row       <= row_addr;
            read_window    <= win;
            rows_left      <= rows_left - 16'h0001;
            row_addr       <= row_addr + 16'h0001 +
                              (row_addr[0] ?
                               {regs[IDX_G2_SKIP + 7'h01], regs[IDX_G2_SKIP]} :
                               {regs[IDX_G1_SKIP + 7'h01], regs[IDX_G1_SKIP]});
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Exposure and kneepoint outputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      expose_group1 <= 1'b0;
      expose_group2 <= 1'b0;
      knee1_pulse   <= 1'b0;
      knee2_pulse   <= 1'b0;
    end else if (state == ST_EXPOSE) begin
      expose_group1 <= cfg.integ_ext ? ext_int1 : !exp1_done;
      expose_group2 <= cfg.integ_ext ? (cfg.integ_dual ? ext_int2 : ext_int1) :
                       (cfg.integ_dual ? (exp_cnt < cfg.group2_exposure_len)
                                       : !exp1_done);
      knee1_pulse   <= !cfg.integ_ext && cfg.hdr_slopes >= SLOPES_KNEE1 &&
                       exp_cnt == cfg.knee1_exposure;
      knee2_pulse   <= !cfg.integ_ext && cfg.hdr_slopes >= SLOPES_KNEE2 &&
                       exp_cnt == cfg.knee2_exposure;
    end else begin
      expose_group1 <= 1'b0;
      expose_group2 <= 1'b0;
      knee1_pulse   <= 1'b0;
      knee2_pulse   <= 1'b0;
    end
  end

  assign seq_busy = (state != ST_IDLE);

endmodule
